// [logic/ctpwm_top.sv]
// Function
// - pwm mode toggles flop on duty compare match
// - overflow toggles flop, clears count, raises irq
// - flop starts from init bit, reset clears
// - inverted pwm pin is complement of flop
// - running pwm duty write waits for irq
// - stopped duty write takes effect at once
// - duty read returns active value during pwm
// - stopping holds the pwm pin level
// - clearing control bit 3 stops counter
// - bit 7 is init bit, clear drives pin high
// - pwm mode also offers fc, fc/2, fs
// - timer mode cascades into 16-bit counter
// - period match raises irq, clears, continues
// - period register unbuffered, takes effect immediately
// - low control holds clock, modes; high bit3 starts
// - taps fc/2^11,7,5,3; fs/2^3 replaces slowest
`timescale 1ns/1ns
`include "ctpwm_defs.svh"
module ctpwm_top (
   input  wire logic                       clk_in,
   input  wire logic                       resetn_in,
   input  wire ctpwm_pkg::ctpwm_avmm_req_t avmm_in,
   input  wire logic                       fs_tick_in,
   output logic [31:0]                     readdata_out,
   output logic                            waitrequest_out,
   output logic                            pwm_out_n_out,
   output logic                            match_irq_out
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]  ctrl_low_q;
   logic [7:0]  ctrl_high_q;
   logic [15:0] period_q;
   logic [7:0]  duty_shadow_q;
   logic [7:0]  duty_active_q;
   logic [7:0]  clk_cfg_q;
   logic [15:0] count_q;
   logic [15:0] count_d;
   logic        ff_q;
   logic        ff_d;
   logic        pin_q;
   logic        irq_q;
   logic [10:0] prescale_q;
   logic [2:0]  fs_div_q;
   logic        wait_q;
   logic [31:0] rdata_q;
   logic [31:0] rd_mux;
   logic        tick;

   function automatic logic ctpwm_tap(input logic [10:0] pre, input logic [10:0] mask);
      return (pre & mask) == mask;
   endfunction

   function automatic logic ctpwm_hit(input logic [4:0] addr, input logic [4:0] ofs);
      return addr == ofs;
   endfunction

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   // one wait state: a write is seen with waitrequest high, taken one edge later; read data loads on the edge where it is high
   wire         wr_fire     = avmm_in.write & ~wait_q & avmm_in.byteenable[0];
   wire         rd_load     = avmm_in.read & wait_q;
   wire [7:0]   wbyte       = avmm_in.writedata[7:0];
   wire [4:0]   addr        = avmm_in.address;
   wire         wr_ctrl_low = wr_fire & ctpwm_hit(addr, `CTPWM_OFS_CTRL_LOW);
   wire         wr_ctrl_hi  = wr_fire & ctpwm_hit(addr, `CTPWM_OFS_CTRL_HIGH);
   wire         wr_per_low  = wr_fire & ctpwm_hit(addr, `CTPWM_OFS_PERIOD_LOW);
   wire         wr_per_high = wr_fire & ctpwm_hit(addr, `CTPWM_OFS_PERIOD_HIGH);
   wire         wr_duty     = wr_fire & ctpwm_hit(addr, `CTPWM_OFS_DUTY);
   wire         wr_cfg      = wr_fire & ctpwm_hit(addr, `CTPWM_OFS_CLK_CFG);

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   wire [2:0]   mode_high   = ctrl_high_q[`CTPWM_MODE_HI:`CTPWM_MODE_LO];
   wire [2:0]   mode_low    = ctrl_low_q[`CTPWM_MODE_HI:`CTPWM_MODE_LO];
   wire         is_pwm      = mode_high == `CTPWM_MODE_PWM8;
   wire         is_tim16    = (mode_high == `CTPWM_MODE_TIM16_HIGH) &&
                              (mode_low == `CTPWM_MODE_TIM16_LOW);
   ctpwm_pkg::ctpwm_mode_t mode;
   assign mode = is_pwm ? ctpwm_pkg::CTPWM_PWM8 :
                 is_tim16 ? ctpwm_pkg::CTPWM_TIM16 : ctpwm_pkg::CTPWM_IDLE;
   wire         run_bit     = ctrl_high_q[`CTPWM_BIT_RUN];
   wire         running     = run_bit & (mode != ctpwm_pkg::CTPWM_IDLE);
   wire         subclock    = clk_cfg_q[`CTPWM_CFG_SUBCLOCK];
   wire         slow_tap    = clk_cfg_q[`CTPWM_CFG_SLOW_TAP];

   // ----------------------------------------------------------------
   // source clock
   // ----------------------------------------------------------------
   // pwm takes its select from the upper control, the 16-bit timer from the lower
   wire [2:0]   sel = is_pwm ? ctrl_high_q[`CTPWM_CKSEL_HI:`CTPWM_CKSEL_LO]
                             : ctrl_low_q[`CTPWM_CKSEL_HI:`CTPWM_CKSEL_LO];
   wire         fc_ok    = ~subclock;
   wire         fs8_tick = fs_tick_in & (fs_div_q == `CTPWM_FS_DIV3_LAST);

   always_comb begin
      case (sel)
         `CTPWM_CKSEL_DIV11: tick = (slow_tap | subclock) ? fs8_tick :
                                    ctpwm_tap(prescale_q, `CTPWM_MASK_DIV11);
         `CTPWM_CKSEL_DIV7:  tick = fc_ok & ctpwm_tap(prescale_q, `CTPWM_MASK_DIV7);
         `CTPWM_CKSEL_DIV5:  tick = fc_ok & ctpwm_tap(prescale_q, `CTPWM_MASK_DIV5);
         `CTPWM_CKSEL_DIV3:  tick = fc_ok & ctpwm_tap(prescale_q, `CTPWM_MASK_DIV3);
         `CTPWM_CKSEL_FS:    tick = is_pwm & fs_tick_in;
         `CTPWM_CKSEL_FC_DIV2: tick = is_pwm & fc_ok &
                                      ctpwm_tap(prescale_q, `CTPWM_MASK_DIV1);
         `CTPWM_CKSEL_FC:    tick = is_pwm & fc_ok;
         default:            tick = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // counter events
   // ----------------------------------------------------------------
   wire         pwm_tick  = running & is_pwm & tick;
   wire         ovf       = pwm_tick & (count_q[7:0] == `CTPWM_CNT8_LAST);
   wire         cmp       = pwm_tick & (count_q[7:0] == duty_active_q);
   wire         tmatch    = running & is_tim16 & tick & (count_q == period_q);
   // a write that stops the timer leaves the flop alone, so the pin holds
   wire         ff_load   = wr_ctrl_hi & ~running;

   always_comb begin
      count_d = count_q;
      if (!run_bit) begin
         count_d = `CTPWM_RST_REG16;
      end else if (pwm_tick) begin
         count_d = {8'h00, count_q[7:0] + 8'h01};
      end else if (running & is_tim16 & tick) begin
         count_d = tmatch ? `CTPWM_RST_REG16 : count_q + 16'h0001;
      end
   end

   always_comb begin
      if (ff_load) begin
         ff_d = wbyte[`CTPWM_BIT_FF_INIT];
      end else if (running) begin
         ff_d = ff_q ^ cmp ^ ovf;
      end else begin
         ff_d = ff_q;
      end
   end

   // ----------------------------------------------------------------
   // register read mux
   // ----------------------------------------------------------------
   always_comb begin
      case (addr)
         `CTPWM_OFS_CTRL_LOW:    rd_mux = {24'h000000, ctrl_low_q};
         `CTPWM_OFS_CTRL_HIGH:   rd_mux = {24'h000000, ctrl_high_q};
         `CTPWM_OFS_PERIOD_LOW:  rd_mux = {24'h000000, period_q[7:0]};
         `CTPWM_OFS_PERIOD_HIGH: rd_mux = {24'h000000, period_q[15:8]};
         `CTPWM_OFS_DUTY:        rd_mux = {24'h000000, duty_active_q};
         `CTPWM_OFS_CLK_CFG:     rd_mux = {24'h000000, clk_cfg_q};
         `CTPWM_OFS_STATUS:      rd_mux = {14'h0000, running, ff_q, count_q};
         default:                rd_mux = 32'h00000000;
      endcase
   end

   // ----------------------------------------------------------------
   // flops
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h00000000;
      end else begin
         wait_q  <= ~((avmm_in.read | avmm_in.write) & wait_q);
         rdata_q <= rd_load ? rd_mux : rdata_q;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_low_q  <= `CTPWM_RST_REG8;
         ctrl_high_q <= `CTPWM_RST_REG8;
         clk_cfg_q   <= `CTPWM_RST_REG8;
         period_q    <= `CTPWM_RST_REG16;
      end else begin
         ctrl_low_q  <= wr_ctrl_low ? wbyte : ctrl_low_q;
         ctrl_high_q <= wr_ctrl_hi ? wbyte : ctrl_high_q;
         clk_cfg_q   <= wr_cfg ? wbyte : clk_cfg_q;
         period_q[7:0]  <= wr_per_low ? wbyte : period_q[7:0];
         period_q[15:8] <= wr_per_high ? wbyte : period_q[15:8];
      end
   end

   // a write in the same cycle as the transfer lands in the holding stage only;
   // the transfer moves the older holding value
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         duty_shadow_q <= `CTPWM_RST_REG8;
         duty_active_q <= `CTPWM_RST_REG8;
      end else begin
         duty_shadow_q <= wr_duty ? wbyte : duty_shadow_q;
         if (wr_duty && !(running && is_pwm)) begin
            duty_active_q <= wbyte;
         end else if (ovf) begin
            duty_active_q <= duty_shadow_q;
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         prescale_q <= 11'h000;
         fs_div_q   <= 3'h0;
         count_q    <= `CTPWM_RST_REG16;
         ff_q       <= 1'b0;
         pin_q      <= 1'b1;
         irq_q      <= 1'b0;
      end else begin
         prescale_q <= prescale_q + 11'h001;
         fs_div_q   <= fs_tick_in ? fs_div_q + 3'h1 : fs_div_q;
         count_q    <= count_d;
         ff_q       <= ff_d;
         pin_q      <= ~ff_d;
         irq_q      <= ovf | tmatch;
      end
   end

   assign readdata_out    = rdata_q;
   assign waitrequest_out = wait_q;
   assign pwm_out_n_out   = pin_q;
   assign match_irq_out   = irq_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [8:0] gap_q;
   logic       seen_q;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         gap_q  <= 9'h000;
         seen_q <= 1'b0;
      end else begin
         gap_q  <= (ovf || !running) ? 9'h000 : gap_q + {8'h00, pwm_tick};
         seen_q <= running & (seen_q | ovf);
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_ovf_evt;
      ovf ##1 match_irq_out;
   endsequence

   sequence s_stop_write;
      wr_ctrl_hi && !running && !wbyte[`CTPWM_BIT_FF_INIT];
   endsequence

   sequence s_bus_take;
      (avmm_in.read || avmm_in.write) && waitrequest_out;
   endsequence

   sequence s_stop_edge;
      wr_ctrl_hi && running && !wbyte[`CTPWM_BIT_RUN];
   endsequence

   a_cmp_toggle: assert property (cmp && !ovf |=> ff_q == !$past(ff_q))
      else $error("compare match did not toggle flop");
   a_ovf_clear: assert property (s_ovf_evt |-> count_q[7:0] == 8'h00)
      else $error("overflow did not clear counter with irq");
   a_ovf_toggle: assert property (ovf && !cmp |=> ff_q != $past(ff_q))
      else $error("overflow did not toggle flop");
   a_init_load: assert property (ff_load |=> ff_q == $past(wbyte[7]))
      else $error("flop did not take init bit");
   a_pin_inverse: assert property (pwm_out_n_out != ff_q)
      else $error("pwm pin not complement of flop");
   a_duty_hold: assert property (wr_duty && running && is_pwm && !ovf
      |=> duty_active_q == $past(duty_active_q) ##0 duty_shadow_q == $past(wbyte))
      else $error("running duty write reached compare early");
   a_duty_direct: assert property (wr_duty && !running |=> duty_active_q == $past(wbyte))
      else $error("stopped duty write not immediate");
   a_duty_read: assert property (rd_load && addr == `CTPWM_OFS_DUTY
      |=> readdata_out[7:0] == $past(duty_active_q) && !waitrequest_out)
      else $error("duty read did not return active value");
   a_stop_hold: assert property (!running && !ff_load |=> $stable(pwm_out_n_out))
      else $error("pin moved while stopped");
   a_run_clear: assert property (!run_bit |=> count_q == 16'h0000)
      else $error("counter not cleared when stopped");
   a_clear_high: assert property (s_stop_write |=> pwm_out_n_out)
      else $error("clearing init bit did not raise pin");
   a_fast_src: assert property (running && is_pwm && !subclock
      && sel == `CTPWM_CKSEL_FC |-> tick)
      else $error("undivided source not ticking");
   a_tim16_step: assert property (running && is_tim16 && tick && !tmatch
      |=> count_q == $past(count_q) + 16'h0001)
      else $error("16-bit counter did not step");
   a_period_match: assert property (tmatch |=> match_irq_out && count_q == 16'h0000)
      else $error("period match did not clear and interrupt");
   a_period_live: assert property (wr_per_low |=> period_q[7:0] == $past(wbyte))
      else $error("period write not immediate");
   a_tap_div3: assert property (!subclock && sel == `CTPWM_CKSEL_DIV3 && tick
      |-> prescale_q[2:0] == 3'h7)
      else $error("fc/8 tap misaligned");
   a_pwm_period: assert property (ovf && seen_q |-> gap_q == `CTPWM_PWM_GAP)
      else $error("pwm period not 256 source clocks");
   a_slow_src: assert property (subclock && sel != `CTPWM_CKSEL_DIV11
      && sel != `CTPWM_CKSEL_FS |-> !tick)
      else $error("fc source active in subclock mode");

   // ----------------------------------------------------------------
   // bus and event checks
   // ----------------------------------------------------------------
   // one wait cycle per request keeps the bus timing fixed for software
   a_bus_answer: assert property (s_bus_take |=> !waitrequest_out)
      else $error("request not answered after one wait cycle");
   a_bus_release: assert property (!waitrequest_out |=> waitrequest_out)
      else $error("waitrequest low for more than one cycle");
   a_wr_early: assert property (waitrequest_out |-> !wr_fire)
      else $error("write taken while waitrequest high");
   a_duty_xfer: assert property (ovf |=> duty_active_q == $past(duty_shadow_q))
      else $error("holding stage not moved at overflow");
   // a write meeting the transfer waits a full period rather than tearing the compare
   a_duty_clash: assert property (wr_duty && ovf |=> duty_shadow_q == $past(wbyte))
      else $error("colliding duty write lost");
   a_ovf_irq: assert property (ovf |=> match_irq_out)
      else $error("overflow without interrupt");
   a_irq_single: assert property (match_irq_out |=> !match_irq_out)
      else $error("interrupt longer than one cycle");
   a_irq_stopped: assert property (!running |=> !match_irq_out)
      else $error("interrupt while stopped");
   a_pwm_step: assert property (pwm_tick && !ovf
      |=> count_q[7:0] == $past(count_q[7:0]) + 8'h01)
      else $error("8-bit counter did not step");
   a_pwm_upper: assert property (pwm_tick |=> count_q[15:8] == 8'h00)
      else $error("upper counter moved in pwm mode");
   a_stop_count: assert property (s_stop_edge |=> ##1 count_q == 16'h0000)
      else $error("counter not cleared after stop");
   a_stop_keep: assert property (s_stop_edge ##1 !ff_load |=> $stable(pwm_out_n_out))
      else $error("pin moved after stop write");
   a_slow_fs: assert property ((slow_tap || subclock) && sel == `CTPWM_CKSEL_DIV11 && tick
      |-> fs_tick_in && fs_div_q == `CTPWM_FS_DIV3_LAST)
      else $error("slowest tap not taken from fs/8");

endmodule

// [logic/ctpwm_defs.svh]
`ifndef CTPWM_DEFS_SVH
`define CTPWM_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CTPWM_OFS_CTRL_LOW     5'h00
`define CTPWM_OFS_CTRL_HIGH    5'h04
`define CTPWM_OFS_PERIOD_LOW   5'h08
`define CTPWM_OFS_PERIOD_HIGH  5'h0c
`define CTPWM_OFS_DUTY         5'h10
`define CTPWM_OFS_CLK_CFG      5'h14
`define CTPWM_OFS_STATUS       5'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTPWM_BIT_FF_INIT      7
`define CTPWM_BIT_RUN          3
`define CTPWM_CKSEL_HI         6
`define CTPWM_CKSEL_LO         4
`define CTPWM_MODE_HI          2
`define CTPWM_MODE_LO          0
`define CTPWM_CFG_SLOW_TAP     0
`define CTPWM_CFG_SUBCLOCK     1
`define CTPWM_STAT_FF          16
`define CTPWM_STAT_RUN         17

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define CTPWM_MODE_PWM8        3'h2
`define CTPWM_MODE_TIM16_LOW   3'h3
`define CTPWM_MODE_TIM16_HIGH  3'h4
`define CTPWM_CKSEL_DIV11      3'h0
`define CTPWM_CKSEL_DIV7       3'h1
`define CTPWM_CKSEL_DIV5       3'h2
`define CTPWM_CKSEL_DIV3       3'h3
`define CTPWM_CKSEL_FS         3'h4
`define CTPWM_CKSEL_FC_DIV2    3'h5
`define CTPWM_CKSEL_FC         3'h6
`define CTPWM_MASK_DIV11       11'h7ff
`define CTPWM_MASK_DIV7        11'h07f
`define CTPWM_MASK_DIV5        11'h01f
`define CTPWM_MASK_DIV3        11'h007
`define CTPWM_MASK_DIV1        11'h001
`define CTPWM_FS_DIV3_LAST     3'h7
`define CTPWM_CNT8_LAST        8'hff
`define CTPWM_PWM_GAP          9'h0ff
`define CTPWM_RST_REG8         8'h00
`define CTPWM_RST_REG16        16'h0000

`endif

// [logic/ctpwm_pkg.sv]
package ctpwm_pkg;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [4:0]  address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } ctpwm_avmm_req_t;

   typedef enum logic [1:0] {
      CTPWM_IDLE  = 2'b00,
      CTPWM_PWM8  = 2'b01,
      CTPWM_TIM16 = 2'b10
   } ctpwm_mode_t;

endpackage

// [verif/ctpwm_top_test.sv]
`timescale 1ns/1ns
`include "ctpwm_defs.svh"
module ctpwm_top_test;
   logic                       clk_in;
   logic                       resetn_in;
   logic                       fs_tick_in;
   ctpwm_pkg::ctpwm_avmm_req_t avmm_in;
   logic [31:0]                readdata_out;
   logic                       waitrequest_out;
   logic                       pwm_out_n_out;
   logic                       match_irq_out;
   logic [1:0]                 fs_div_q;
   int                         error_cnt;
   int                         checks;

   ctpwm_top DUT (
      .clk_in          (clk_in),
      .resetn_in       (resetn_in),
      .avmm_in         (avmm_in),
      .fs_tick_in      (fs_tick_in),
      .readdata_out    (readdata_out),
      .waitrequest_out (waitrequest_out),
      .pwm_out_n_out   (pwm_out_n_out),
      .match_irq_out   (match_irq_out)
   );

   // ----------------------------------------------------------------
   // clock and subclock tick, fs is one pulse every four cycles
   // ----------------------------------------------------------------
   initial clk_in = 1'h0;
   always #4 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      if (!resetn_in) begin
         fs_div_q   <= 2'h0;
         fs_tick_in <= 1'h0;
      end else begin
         fs_div_q   <= fs_div_q + 2'h1;
         fs_tick_in <= (fs_div_q == 2'h3);
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task test_done();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // holds the request until waitrequest is seen low at a rising edge
   task bus(input logic wr_in, input logic [4:0] addr, input logic [7:0] data,
            input logic [3:0] be, output logic [31:0] rdata);
      int n;
      n = 0;
      @(posedge clk_in);
      avmm_in <= '{read: !wr_in, write: wr_in, address: addr, byteenable: be,
                   writedata: {24'h000000, data}};
      do begin
         @(posedge clk_in);
         n++;
      end while (waitrequest_out !== 1'h0 && n < 100);
      rdata = readdata_out;
      if (n >= 100) chk(32'h1, 32'h0, "bus answer");
      avmm_in <= '0;
   endtask

   task wr(input logic [4:0] addr, input logic [7:0] data);
      logic [31:0] d;
      bus(1'h1, addr, data, 4'h1, d);
   endtask

   task rd(input logic [4:0] addr, input logic [31:0] exp, input string what);
      logic [31:0] d;
      bus(1'h0, addr, 8'h00, 4'hf, d);
      chk(d, exp, what);
   endtask

   task wait_irq(input int lim, output int n);
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (match_irq_out !== 1'h1 && n < lim);
   endtask

   task period(input int exp, input string what);
      int n;
      wait_irq(70000, n);
      wait_irq(70000, n);
      chk(n, exp, what);
   endtask

   // one full period sampled from an irq edge holds each level a fixed count
   task low_cnt(input int exp);
      int n;
      int i;
      wait_irq(70000, n);
      n = 0;
      for (i = 0; i < 256; i++) begin
         @(posedge clk_in);
         if (pwm_out_n_out === 1'h0) n++;
      end
      chk(n, exp, "pin low cycles");
   endtask

   function automatic int exp_low(input logic ff, input logic [7:0] d);
      return ff ? int'(d) + 1 : 255 - int'(d);
   endfunction

   function automatic logic [7:0] ctl(input logic ff, input logic [2:0] ck, input logic run);
      return {ff, ck, run, `CTPWM_MODE_PWM8};
   endfunction

   task start_pwm(input logic ff, input logic [2:0] ck);
      wr(`CTPWM_OFS_CTRL_HIGH, ctl(ff, ck, 1'h0));
      wr(`CTPWM_OFS_CTRL_HIGH, ctl(ff, ck, 1'h1));
   endtask

   // ----------------------------------------------------------------
   // watchdog, well beyond the roughly 66k cycles of the sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (90000) @(posedge clk_in);
      error_cnt++;
      $display("mismatch at %0t: run did not finish", $time);
      test_done();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0]  d1;
      logic [7:0]  d3;
      logic [15:0] per;
      logic        held;
      logic [31:0] rdw;
      int          n;
      int          bad;
      int          i;
      logic [2:0]  cks[5];
      int          dvs[5];
      cks = '{3'h4, 3'h5, 3'h6, 3'h3, 3'h2};
      dvs = '{4, 2, 1, 8, 32};
      avmm_in    = '0;
      resetn_in  = 1'h0;
      error_cnt  = 0;
      checks     = 0;
      void'($urandom(32'h8054b38a));
      repeat (6) @(posedge clk_in);
      chk(32'(pwm_out_n_out), 32'h1, "pin in reset");
      chk(32'({waitrequest_out, match_irq_out}), 32'h2, "bus and irq in reset");
      resetn_in <= 1'h1;
      for (i = 0; i < 8; i++) rd(5'(4 * i), 32'h0, "reset value or unmapped");

      d1 = 8'h01 + 8'($urandom_range(253));
      d3 = 8'($urandom_range(255));
      wr(`CTPWM_OFS_DUTY, d1);
      rd(`CTPWM_OFS_DUTY, {24'h0, d1}, "stopped duty write");
      bus(1'h1, `CTPWM_OFS_DUTY, 8'h55, 4'h0, rdw);
      rd(`CTPWM_OFS_DUTY, {24'h0, d1}, "byteenable low ignored");
      start_pwm(1'h0, `CTPWM_CKSEL_FC);
      low_cnt(exp_low(1'h0, d1));
      period(256, "pwm period fc");
      wait_irq(1000, n);
      wr(`CTPWM_OFS_DUTY, 8'h00);
      rd(`CTPWM_OFS_DUTY, {24'h0, d1}, "old duty before transfer");
      low_cnt(exp_low(1'h0, 8'h00));
      rd(`CTPWM_OFS_DUTY, 32'h0, "duty after transfer");

      // stop mid-period: level held, no further events
      repeat (37 + $urandom_range(150)) @(posedge clk_in);
      wr(`CTPWM_OFS_CTRL_HIGH, ctl(1'h0, `CTPWM_CKSEL_FC, 1'h0));
      repeat (2) @(posedge clk_in);
      held = pwm_out_n_out;
      bad = 0;
      for (i = 0; i < 300; i++) begin
         @(posedge clk_in);
         if (pwm_out_n_out !== held || match_irq_out !== 1'h0) bad++;
      end
      chk(bad, 32'h0, "pin held after stop");
      rd(`CTPWM_OFS_STATUS, {14'h0, 1'h0, ~held, 16'h0}, "status after stop");
      wr(`CTPWM_OFS_CTRL_HIGH, ctl(1'h0, `CTPWM_CKSEL_FC, 1'h0));
      repeat (3) @(posedge clk_in);
      chk(32'(pwm_out_n_out), 32'h1, "init bit clear drives pin high");
      wr(`CTPWM_OFS_CTRL_HIGH, ctl(1'h1, `CTPWM_CKSEL_FC, 1'h0));
      repeat (3) @(posedge clk_in);
      chk(32'(pwm_out_n_out), 32'h0, "init bit set drives pin low");
      rd(`CTPWM_OFS_STATUS, 32'h10000, "flop level in status");
      wr(`CTPWM_OFS_DUTY, d3);
      start_pwm(1'h1, `CTPWM_CKSEL_FC);
      low_cnt(exp_low(1'h1, d3));

      // source clock selections
      for (i = 0; i < 5; i++) begin
         start_pwm(1'h0, cks[i]);
         period(256 * dvs[i], "source clock period");
      end
      wr(`CTPWM_OFS_CLK_CFG, 8'h01);
      start_pwm(1'h0, `CTPWM_CKSEL_DIV11);
      period(256 * 32, "slow tap fs/8");
      wr(`CTPWM_OFS_CLK_CFG, 8'h02);
      start_pwm(1'h0, `CTPWM_CKSEL_FC);
      wait_irq(600, n);
      chk(n, 32'd600, "fc source in subclock mode");
      start_pwm(1'h0, `CTPWM_CKSEL_FS);
      period(256 * 4, "fs source in subclock mode");
      wr(`CTPWM_OFS_CLK_CFG, 8'h00);

      // 16-bit timer, period above 255 so the upper counter takes part
      wr(`CTPWM_OFS_CTRL_HIGH, 8'h00);
      per = 16'h0100 + 16'($urandom_range(63));
      wr(`CTPWM_OFS_PERIOD_LOW, per[7:0]);
      wr(`CTPWM_OFS_PERIOD_HIGH, per[15:8]);
      wr(`CTPWM_OFS_CTRL_LOW, 8'h33);
      wr(`CTPWM_OFS_CTRL_HIGH, 8'h04);
      wr(`CTPWM_OFS_CTRL_HIGH, 8'h0c);
      period((int'(per) + 1) * 8, "16-bit match period");
      wr(`CTPWM_OFS_CTRL_HIGH, 8'h04);
      // an interrupt launched by the stopping edge itself is let pass
      @(posedge clk_in);
      wait_irq(3000, n);
      chk(n, 32'd3000, "timer stopped");

      // fc/2^11 and fc/2^7 taps through the 16-bit timer, short period
      wr(`CTPWM_OFS_PERIOD_LOW, 8'h02);
      wr(`CTPWM_OFS_PERIOD_HIGH, 8'h00);
      for (i = 0; i < 2; i++) begin
         wr(`CTPWM_OFS_CTRL_LOW, {1'h0, 3'(i), 1'h0, `CTPWM_MODE_TIM16_LOW});
         wr(`CTPWM_OFS_CTRL_HIGH, 8'h0c);
         period(3 * (i == 0 ? 2048 : 128), "prescaled tap period");
         wr(`CTPWM_OFS_CTRL_HIGH, 8'h04);
      end
      test_done();
   end
endmodule
